// >>> hw/paging_alpha_fragment_checker.sv
// Purpose: Checks and decodes received alphanumeric paging message fragments.
// Assumes: Decoded code words arrive one per word_valid pulse, first and last marked.
// Notes: Registers on classic Wishbone; one mail-drop area read through the bus window.
// Summary of operation
// R1 - The check sum starts at zero and adds every information bit of every word of a fragment; the code counts the ten check field bits as zero.
// R2 - Each word is added as three values: bits 0-7, bits 8-15 and bits 16-20.
// R3 - The check value is the ones complement of the sum cut to ten bits, compared to the field.
// R4 - A set continuation flag means more fragments follow; a clear one marks the last fragment.
// R5 - One frame carries at most 84 words of a message, so longer messages come as fragments.
// R6 - Fragment numbers run 11 for the initial fragment, then 00, 01, 10, 00 and on, never 11.
// R7 - The sender numbers messages per address from zero to at most 63, then rolls over.
// R8 - The receiver's message-number rollover point is a software setting, not a constant.
// R9 - The message number ties fragments of one message; distinct messages use distinct numbers.
// R10 - With the retrieval flag set, numbers must run in order per address, a skip is reported.
// R11 - A message with the retrieval flag clear is never tracked and never reports a miss.
// R12 - A mail-drop message is written into the one shared mail area, overwriting what it held.
// R13 - Later fragments decode their two control bits as 00 none, 01 reserved, 10 default, 11 alt.
// R14 - A later fragment's first word holds check, continuation, fragment, number and control bits.
`include "paging_defs.svh"

module paging_alpha_fragment_checker import paging_pkg::*; #(
	parameter int ADDR_W     = 2,
	parameter int MAIL_DEPTH = 84,
	parameter int MAIL_AW    = 7
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [11:0]       wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              word_valid,
	input  wire logic              word_first,
	input  wire logic              word_last,
	input  wire logic [ADDR_W-1:0] word_addr,
	input  wire logic [20:0]       word_data,
	output logic                   frag_done,
	output frag_info_t             frag_info,
	output logic                   msg_valid,
	output logic [20:0]            msg_data,
	output logic                   msg_mail,
	output logic                   irq
);

	localparam int NSLOT = 1 << ADDR_W;

	logic [31:0]            ctrl_reg;
	logic [`ST_WIDTH-1:0]   status_reg;
	logic [`ST_WIDTH-1:0]   mask_reg;
	logic [`ST_WIDTH-1:0]   status_set;
	logic [15:0]            sum_reg;
	logic [15:0]            sum_next;
	logic [15:0]            base;
	frag_hdr_t              hdr_reg;
	frag_hdr_t              hdr_now;
	logic [ADDR_W-1:0]      addr_reg;
	logic [ADDR_W-1:0]      addr_now;
	logic [7:0]             cnt_reg;
	logic [7:0]             cnt_now;
	logic                   mail_cur_reg;
	logic [9:0]             check_calc;
	logic [9:0]             check_reg;
	logic                   check_ok;
	logic                   initial_now;
	logic                   missed_now;
	logic                   seq_err_now;
	logic                   too_long_now;
	logic                   in_frag_reg;
	logic [5:0]             roll_max;
	logic                   enable;
	logic                   wb_req;
	logic                   wr_en;
	logic                   frag_end;
	logic [20:0]            masked;
	logic                   mail_sel;
	logic [11:0]            mail_off;
	logic [MAIL_AW:0]       mail_len_reg;
	logic [20:0]            mail_mem [MAIL_DEPTH];
	logic                   seen_reg     [NSLOT];
	logic [5:0]             exp_num_reg  [NSLOT];
	logic [5:0]             cur_num_reg  [NSLOT];
	logic [1:0]             last_frag_reg[NSLOT];
	logic                   open_reg     [NSLOT];
	logic                   mail_reg     [NSLOT];

	function automatic logic [15:0] group_sum(input logic [20:0] w);
		group_sum = 16'(w[7:0]) + 16'(w[15:8]) + 16'(w[20:16]); // R2
	endfunction

	function automatic logic [1:0] next_frag(input logic [1:0] f);
		next_frag = (f[1]) ? 2'h0 : f + 2'h1; // R6
	endfunction

	assign roll_max = ctrl_reg[`CTRL_ROLL_LSB +: 6];
	assign enable   = ctrl_reg[`CTRL_EN_BIT];
	assign frag_end = enable && word_valid && word_last;

	// Word-field view of the first word; later words of a fragment keep the latched one
	assign hdr_now     = word_first ? frag_hdr_t'(word_data) : hdr_reg; // R14
	assign addr_now    = word_first ? word_addr : addr_reg;
	assign initial_now = hdr_now.frag_num == `FRAG_INIT; // R6
	assign cnt_now     = word_first ? 8'h01 : cnt_reg + 8'h01;

	// The check field itself counts as zero in the sum it protects
	assign masked   = word_first ? {word_data[20:10], 10'h000} : word_data;
	assign base     = word_first ? 16'h0000 : sum_reg; // R1
	assign sum_next = base + group_sum(masked); // R1
	assign check_calc = ~sum_next[`CHECK_WIDTH-1:0]; // R3
	assign check_ok   = check_calc == hdr_now.check; // R3
	assign too_long_now = cnt_now > 8'(`MAX_FRAME_WORDS); // R5

	always_comb begin
		missed_now  = 1'b0;
		seq_err_now = 1'b0;
		if (initial_now) begin
			// Only messages with the retrieval flag set join the in-order tracking
			if (hdr_now.tail[0] && seen_reg[addr_now]
				&& hdr_now.msg_num != exp_num_reg[addr_now]) begin
				missed_now = 1'b1; // R10 R11
			end
		end else begin
			if (!open_reg[addr_now] || hdr_now.msg_num != cur_num_reg[addr_now]
				|| hdr_now.frag_num != next_frag(last_frag_reg[addr_now])) begin
				seq_err_now = 1'b1; // R6 R9
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sum_reg      <= 16'h0000;
			hdr_reg      <= '0;
			addr_reg     <= '0;
			cnt_reg      <= 8'h00;
			in_frag_reg  <= 1'b0;
			mail_cur_reg <= 1'b0;
		end else if (enable && word_valid) begin
			sum_reg      <= sum_next; // R1
			hdr_reg      <= hdr_now;
			addr_reg     <= addr_now;
			cnt_reg      <= cnt_now;
			in_frag_reg  <= !word_last;
			if (word_first) begin
				mail_cur_reg <= (initial_now) ? hdr_now.tail[1] : mail_reg[addr_now]; // R12
			end
		end
	end

	// Per-address tracking moves only on fragments whose check passed
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < NSLOT; i++) begin
				seen_reg[i]      <= 1'b0;
				exp_num_reg[i]   <= 6'h00;
				cur_num_reg[i]   <= 6'h00;
				last_frag_reg[i] <= 2'h0;
				open_reg[i]      <= 1'b0;
				mail_reg[i]      <= 1'b0;
			end
		end else if (frag_end && check_ok) begin
			open_reg[addr_now]      <= hdr_now.cont; // R4
			last_frag_reg[addr_now] <= hdr_now.frag_num; // R6
			if (initial_now) begin
				cur_num_reg[addr_now] <= hdr_now.msg_num; // R9
				mail_reg[addr_now]    <= hdr_now.tail[1]; // R12
				if (hdr_now.tail[0]) begin
					seen_reg[addr_now]    <= 1'b1; // R10
					exp_num_reg[addr_now] <= (hdr_now.msg_num >= roll_max)
						? 6'h00 : hdr_now.msg_num + 6'h01; // R8 R7
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frag_done <= 1'b0;
			frag_info <= '0;
			check_reg <= 10'h000;
		end else begin
			frag_done <= frag_end;
			if (frag_end) begin
				check_reg                      <= check_calc;
				frag_info.hdr                  <= hdr_now;
				frag_info.addr                 <= 5'(addr_now);
				frag_info.initial_frag         <= initial_now;
				frag_info.check_ok             <= check_ok; // R3
				frag_info.missed               <= check_ok && missed_now; // R10
				frag_info.seq_err              <= check_ok && seq_err_now;
				frag_info.too_long             <= too_long_now; // R5
				// The initial fragment always starts in default character mode
				frag_info.enhanced_fragmenting <= initial_now ? EF_DEFAULT
					: ef_mode_t'({hdr_now.tail[0], hdr_now.tail[1]}); // R13
			end
		end
	end

	// Body words go to the host; mail-drop bodies also land in the mail area
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			msg_valid <= 1'b0;
			msg_data  <= 21'h00_0000;
			msg_mail  <= 1'b0;
		end else begin
			msg_valid <= enable && word_valid && !word_first;
			if (enable && word_valid && !word_first) begin
				msg_data <= word_data;
				msg_mail <= mail_cur_reg; // R12
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mail_len_reg <= '0;
		end else if (enable && word_valid) begin
			if (word_first && initial_now && hdr_now.tail[1]) begin
				mail_len_reg <= '0; // R12
			end else if (!word_first && mail_cur_reg && mail_len_reg < (MAIL_AW+1)'(MAIL_DEPTH)) begin
				mail_mem[mail_len_reg[MAIL_AW-1:0]] <= word_data; // R12
				mail_len_reg <= mail_len_reg + 1'b1;
			end
		end
	end

	// Registered ack: one wait state, dropped the cycle after it is given
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// The mail window runs past 0x1FF, so one address bit cannot mark it
	assign mail_sel = wb_adr_i >= `OFS_MAIL;
	assign mail_off = wb_adr_i - `OFS_MAIL;
	assign wr_en  = wb_req && wb_we_i;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				if (mail_sel) begin
					wb_dat_o <= (mail_off[11:MAIL_AW+2] == '0
						&& mail_off[MAIL_AW+1:2] < (MAIL_AW)'(MAIL_DEPTH))
						? {11'h000, mail_mem[mail_off[MAIL_AW+1:2]]} : 32'h0000_0000;
				end else begin
					unique case (wb_adr_i[7:0])
						`OFS_CTRL:     wb_dat_o <= ctrl_reg;
						`OFS_STATUS:   wb_dat_o <= 32'(status_reg);
						`OFS_MASK:     wb_dat_o <= 32'(mask_reg);
						`OFS_HDR:      wb_dat_o <= 32'(frag_info);
						`OFS_CHECK:    wb_dat_o <= {6'h00, frag_info.hdr.check, 6'h00, check_reg};
						`OFS_MAIL_LEN: wb_dat_o <= 32'(mail_len_reg);
						default:       wb_dat_o <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= `CTRL_RESET;
			mask_reg <= '0;
		end else if (wr_en && !mail_sel) begin
			if (wb_adr_i[7:0] == `OFS_CTRL) begin
				if (wb_sel_i[0]) ctrl_reg[7:0] <= {2'b00, wb_dat_i[5:0]}; // R8
				if (wb_sel_i[1]) ctrl_reg[8]   <= wb_dat_i[8];
			end
			if (wb_adr_i[7:0] == `OFS_MASK && wb_sel_i[0]) begin
				mask_reg <= wb_dat_i[`ST_WIDTH-1:0];
			end
		end
	end

	always_comb begin
		status_set = '0;
		status_set[`ST_DONE]     = frag_done;
		status_set[`ST_CHK_ERR]  = frag_done && !frag_info.check_ok;
		status_set[`ST_MISSED]   = frag_done && frag_info.missed;
		status_set[`ST_SEQ_ERR]  = frag_done && frag_info.seq_err;
		status_set[`ST_TOO_LONG] = frag_done && frag_info.too_long;
		status_set[`ST_EF_RESV]  = frag_done && frag_info.enhanced_fragmenting == EF_RESV;
	end

	// A new event beats a write-one-to-clear landing in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			if (wr_en && !mail_sel && wb_adr_i[7:0] == `OFS_STATUS && wb_sel_i[0]) begin
				status_reg <= (status_reg & ~wb_dat_i[`ST_WIDTH-1:0]) | status_set;
			end else begin
				status_reg <= status_reg | status_set;
			end
		end
	end

	assign irq = |(status_reg & mask_reg);

endmodule

// >>> hw/paging_defs.svh
// Purpose: Register offsets, field positions, reset values and limits of the fragment checker.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes: Included by the design, the checker module and the bench.
`ifndef PAGING_DEFS_SVH
`define PAGING_DEFS_SVH

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_MASK       8'h08
`define OFS_HDR        8'h0C
`define OFS_CHECK      8'h10
`define OFS_MAIL_LEN   8'h14
`define OFS_MAIL       12'h100

`define CTRL_ROLL_LSB  0
`define CTRL_EN_BIT    8
`define CTRL_RESET     32'h0000_013F

`define ST_DONE        0
`define ST_CHK_ERR     1
`define ST_MISSED      2
`define ST_SEQ_ERR     3
`define ST_TOO_LONG    4
`define ST_EF_RESV     5
`define ST_WIDTH       6

`define MAX_FRAME_WORDS 84
`define FRAG_INIT      2'h3
`define CHECK_WIDTH    10

`endif

// >>> hw/paging_pkg.sv
// Purpose: Types shared by the fragment checker and its bench.
// Assumes: 21 information bits per code word.
// Notes: Field order of frag_hdr_t follows the first word of a fragment, bit 20 first.
package paging_pkg;

	typedef struct packed {
		logic [1:0] tail;
		logic [5:0] msg_num;
		logic [1:0] frag_num;
		logic       cont;
		logic [9:0] check;
	} frag_hdr_t;

	typedef enum logic [1:0] {
		EF_NONE    = 2'b00,
		EF_RESV    = 2'b01,
		EF_DEFAULT = 2'b10,
		EF_ALT     = 2'b11
	} ef_mode_t;

	typedef struct packed {
		frag_hdr_t  hdr;
		logic [4:0] addr;
		logic       initial_frag;
		logic       check_ok;
		logic       missed;
		logic       seq_err;
		logic       too_long;
		ef_mode_t   enhanced_fragmenting;
	} frag_info_t;

endpackage

// >>> verification/paging_alpha_fragment_checker_bench.sv
// Purpose: Self-checking bench of the fragment checker.
// Assumes: Four address slots; expectations wait in queues.
// Notes: A monitor pops the oldest expectation at each result.
`include "paging_defs.svh"
module paging_alpha_fragment_checker_bench import paging_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0, rst_n = 1'b0;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, seed = 32'h7cf6_1fb1;
	logic        word_valid, word_first, word_last, frag_done, msg_valid, msg_mail;
	logic [1:0]  word_addr;
	logic [20:0] word_data, msg_data, last_w;
	logic [9:0]  last_k;
	logic        exp_mail = 1'b0;
	logic        mail_slot [4] = '{default: 1'b0};
	frag_info_t  frag_info;
	frag_info_t  fq[$];
	logic [31:0] rq[$];
	int          n_errors = 0, n_compared = 0;
	always #4 clock = ~clock;
	paging_alpha_fragment_checker #(.ADDR_W(2)) paging_alpha_fragment_checker_inst (.*);
	word_source word_source_inst (.*);
	task automatic ck(string nm, logic [39:0] e, logic [39:0] v);
		n_compared++;
		if (v !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock) begin
		if (frag_done === 1'b1)
			ck("frag_info", fq.size() ? 40'(fq.pop_front()) : 40'hFF_FFFF_FFFF, 40'(frag_info));
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			ck("read", rq.size() ? rq.pop_front() : 32'hFFFF_FFFF, wb_dat_o);
		if (msg_valid === 1'b1)
			ck("msg_mail", exp_mail, msg_mail);
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic drain();
		int n;
		for (n = 0; n < 300 && fq.size() + rq.size() > 0; n++) @(posedge clock);
		if (n == 300) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic wb(logic we, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{wb_cyc_i, wb_stb_i} <= 2'h3;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n == 50) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic ckirq(logic e);
		#1;
		ck("irq", e, irq);
	endtask
	// Header fields t, n, f, c; slot a; nb body words; forced check error and flags
	task automatic frag(int t, n, f, c, a, nb, bad, ms, sq);
		logic [20:0] w[$];
		logic [9:0]  s;
		frag_info_t  e;
		w.push_back({2'(t), 6'(n), 2'(f), 1'(c), 10'h000});
		for (int i = 0; i < nb; i++) w.push_back(21'(rnd()));
		s = '0;
		foreach (w[i]) s += 10'(w[i][7:0]) + 10'(w[i][15:8]) + 10'(w[i][20:16]);
		w[0][9:0] = ~s ^ 10'(bad);
		last_k = ~s;
		last_w = w[w.size() - 1];
		e.hdr = w[0];
		e.addr = 5'(a);
		e.initial_frag = (e.hdr.frag_num == `FRAG_INIT);
		e.check_ok = !bad;
		e.missed = 1'(ms);
		e.seq_err = 1'(sq);
		e.too_long = (w.size() > `MAX_FRAME_WORDS);
		e.enhanced_fragmenting = e.initial_frag ? EF_DEFAULT
			: ef_mode_t'({e.hdr.tail[0], e.hdr.tail[1]});
		// Later fragments inherit the mail flag of the slot's accepted initial fragment
		exp_mail = e.initial_frag ? e.hdr.tail[1] : mail_slot[a];
		if (e.initial_frag && !bad) mail_slot[a] = e.hdr.tail[1];
		fq.push_back(e);
		word_source_inst.send(2'(a), w);
		drain();
	endtask
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(12'h000, `CTRL_RESET);
		rd(12'h008, 32'h0000_0000);
		rd(12'h0FC, 32'h0000_0000);
		frag(1, 0, 3, 1, 0, 3, 0, 0, 0);
		rd(12'h004, 32'h0000_0001);
		ckirq(1'b0);
		wb(1'b1, 12'h008, 32'h0000_0001);
		ckirq(1'b1);
		wb(1'b1, 12'h004, 32'h0000_0001);
		ckirq(1'b0);
		$display("test interrupt over");
		frag(3, 0, 0, 1, 0, 1, 0, 0, 0);
		frag(2, 0, 1, 1, 0, 2, 0, 0, 0);
		frag(0, 0, 2, 0, 0, 0, 0, 0, 0);
		frag(1, 0, 0, 0, 0, 1, 0, 0, 1);
		$display("test fragment chain over");
		frag(1, 1, 3, 0, 0, 1, 1, 0, 0);
		rd(12'h010, {6'h00, last_k ^ 10'h001, 6'h00, last_k});
		frag(1, 2, 3, 0, 0, 1, 0, 1, 0);
		frag(0, 9, 3, 0, 0, 1, 0, 0, 0);
		frag(0, 5, 3, 0, 1, 85, 0, 0, 0);
		$display("test numbering over");
		wb(1'b1, 12'h000, 32'h0000_0102);
		frag(1, 2, 3, 0, 2, 1, 0, 0, 0);
		frag(1, 0, 3, 0, 2, 1, 0, 0, 0);
		frag(1, 2, 3, 0, 2, 1, 0, 1, 0);
		$display("test rollover over");
		frag(3, 3, 3, 0, 3, 2, 0, 0, 0);
		rd(12'h014, 32'h0000_0002);
		frag(2, 4, 3, 0, 3, 1, 0, 0, 0);
		rd(12'h014, 32'h0000_0001);
		rd(12'h100, {11'h000, last_w});
		drain();
		$display("test mail drop over");
		report_and_stop();
	end
endmodule

// >>> verification/paging_alpha_fragment_checker_props.sv
// Purpose: Port-level checks of the fragment checker.
// Assumes: Enable stays set while words stream.
// Notes: Helper registers rebuild the sum, count and header of each fragment.
`include "paging_defs.svh"
module paging_alpha_fragment_checker_props import paging_pkg::*; #(
	parameter int ADDR_W = 2
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        word_valid,
	input wire logic        word_first,
	input wire logic        word_last,
	input wire logic [20:0] word_data,
	input wire logic        frag_done,
	input wire frag_info_t  frag_info,
	input wire logic        msg_valid,
	input wire logic [20:0] msg_data
);
	logic [9:0]  sum_reg;
	logic [6:0]  cnt_reg;
	frag_hdr_t   hdr_reg;
	logic [20:0] w;
	// The check field itself counts as zero
	assign w = word_first ? {word_data[20:10], 10'h000} : word_data;
	always_ff @(posedge clock) if (word_valid) sum_reg <= (word_first ? 10'h000 : sum_reg)
		+ 10'(w[7:0]) + 10'(w[15:8]) + 10'(w[20:16]);
	always_ff @(posedge clock) if (word_valid) cnt_reg <= word_first ? 7'h01 : cnt_reg + 7'h01;
	always_ff @(posedge clock) if (word_valid && word_first) hdr_reg <= word_data;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without a taken request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_done_cause: assert property (frag_done |-> $past(word_valid && word_last))
		else $error("fragment end without a last word");
	a_body_echo: assert property (msg_valid |-> $past(word_valid && !word_first)
		&& msg_data == $past(word_data)) else $error("message word not a body word");
	a_check_sum: assert property (
		frag_done |-> frag_info.check_ok == (~sum_reg == frag_info.hdr.check))
		else $error("check result wrong");
	a_hdr_fields: assert property (frag_done |-> frag_info.hdr == hdr_reg)
		else $error("header fields wrong");
	a_frag_kind: assert property (
		frag_done |-> frag_info.initial_frag == (frag_info.hdr.frag_num == `FRAG_INIT)
		&& frag_info.enhanced_fragmenting == (frag_info.initial_frag ? EF_DEFAULT
		: ef_mode_t'({frag_info.hdr.tail[0], frag_info.hdr.tail[1]})))
		else $error("fragment kind wrong");
	a_too_long: assert property (
		frag_done |-> frag_info.too_long == (cnt_reg > `MAX_FRAME_WORDS))
		else $error("length flag wrong");
	c_missed: cover property (frag_done && frag_info.missed);
	c_bad_check: cover property (frag_done && !frag_info.check_ok);
	c_too_long: cover property (frag_done && frag_info.too_long);
endmodule

bind paging_alpha_fragment_checker paging_alpha_fragment_checker_props #(.ADDR_W(ADDR_W))
	paging_alpha_fragment_checker_props_inst (.*);

// >>> verification/word_source.sv
// Purpose: Code word source in place of the radio decoder.
// Assumes: Words of a fragment come back to back.
// Notes: Idle data shows the inverse of the last word, never a stale copy.
module word_source (
	input  wire logic   clock,
	output logic        word_valid,
	output logic        word_first,
	output logic        word_last,
	output logic [1:0]  word_addr,
	output logic [20:0] word_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {word_valid, word_first, word_last, word_addr, word_data} = '0;
	task automatic send(input logic [1:0] a, input logic [20:0] w[$]);
		foreach (w[i]) begin
			@(posedge clock);
			word_valid <= 1'b1;
			word_first <= (i == 0);
			word_last  <= (i == w.size() - 1);
			word_addr  <= a;
			word_data  <= w[i];
		end
		@(posedge clock);
		{word_valid, word_first, word_last} <= 3'h0;
		word_addr <= ~a;
		word_data <= ~w[w.size() - 1];
	endtask
endmodule
